// ### src/block_framer.sv
// blocked file-transfer framer with deframer and payload fifo
`timescale 1ns/10ps

// Function
// - local side sends requests; remote answers each request exactly once.
// - every line character carries seven data bits.
// - both ends run the serial channel at the same baud rate.
// - each request or answer travels in exactly one framed block.
// - a block opens with character 35; receiver starts a block on it.
// - length field counts payload bytes before encoding.
// - length goes as four nibbles plus 64, most significant first.
// - length, payload and checksum characters lie in 64 to 79.
// - each payload byte goes as high nibble then low nibble, plus 64.
// - an 8-bit checksum follows the payload as two nibble characters.
// - payload sum plus checksum is zero modulo 256.
// - a block closes with character 13; total length is 2N plus 8.
module block_framer (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // block request: length latched on start
    input wire logic tx_start,
    input wire logic [15:0] tx_len,
    output logic tx_busy,
    // payload bytes into the fifo
    input wire logic tx_data_valid,
    output logic tx_data_ready,
    input wire logic [7:0] tx_data,
    // line characters to the serial controller
    output logic [6:0] line_tx_char,
    output logic line_tx_valid,
    input wire logic line_tx_ready,
    // line characters from the serial controller
    input wire logic [6:0] line_rx_char,
    input wire logic line_rx_valid,
    // received payload
    output logic [7:0] rx_byte,
    output logic rx_byte_valid,
    output logic [15:0] rx_len,
    output logic [7:0] rx_opcode,
    output logic rx_done,
    output logic rx_error
);
    typedef enum logic [2:0] {
        T_IDLE, T_START, T_LEN, T_DHI, T_DLO, T_CHI, T_CLO, T_STOP
    } tx_state_e;

    tx_state_e state_q;
    tx_state_e state_d;
    logic [15:0] lsh_q;
    logic [15:0] cnt_q;
    logic [1:0] idx_q;
    logic [7:0] byte_q;
    logic [7:0] sum_q;
    logic [7:0] ck_q;
    logic [6:0] char_q;
    logic valid_q;
    logic busy_q;
    logic [6:0] char_d;

    wire fifo_valid;
    wire [7:0] fifo_data;
    wire fifo_ready;

    // the request path holds only payload bytes; start and length characters are made by the framer
    byte_fifo #(
        .WIDTH(framer_pkg::BYTE_W),
        .DEPTH(framer_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(tx_data_valid),
        .in_ready(tx_data_ready),
        .in_data(tx_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_data)
    );

    block_deframer u_rx (
        .clk(clk),
        .rst(rst),
        .line_rx_char(line_rx_char),
        .line_rx_valid(line_rx_valid),
        .rx_byte(rx_byte),
        .rx_byte_valid(rx_byte_valid),
        .rx_len(rx_len),
        .rx_opcode(rx_opcode),
        .rx_done(rx_done),
        .rx_error(rx_error)
    );

    // one character slot: either empty or being taken this cycle
    wire slot_free = !valid_q || line_tx_ready;
    wire need_byte = (state_q == T_DHI);
    // a data slot waits for the fifo rather than send a stale nibble
    wire advance = slot_free && (state_q != T_IDLE) && (!need_byte || fifo_valid);
    wire accept_start = tx_start && (state_q == T_IDLE);
    // negated running sum makes the block total zero
    wire [7:0] ck_d = 8'(8'h00 - sum_q);
    wire last_len = (idx_q == framer_pkg::LAST_NIBBLE);
    wire last_byte = (cnt_q == 16'h1);
    wire zero_len = (cnt_q == framer_pkg::LEN_RESET);
    assign fifo_ready = need_byte && advance;

    always_comb begin
        state_d = state_q;
        char_d = char_q;
        unique case (state_q)
            T_IDLE: begin
                if (accept_start) begin
                    state_d = T_START;
                end
            end
            T_START: begin
                char_d = framer_pkg::START_CHAR;
                state_d = T_LEN;
            end
            T_LEN: begin
                char_d = {framer_pkg::NIB_TAG, lsh_q[15:12]};
                if (last_len) begin
                    state_d = zero_len ? T_CHI : T_DHI;
                end
            end
            T_DHI: begin
                char_d = {framer_pkg::NIB_TAG, fifo_data[7:4]};
                state_d = T_DLO;
            end
            T_DLO: begin
                char_d = {framer_pkg::NIB_TAG, byte_q[3:0]};
                state_d = last_byte ? T_CHI : T_DHI;
            end
            T_CHI: begin
                char_d = {framer_pkg::NIB_TAG, ck_d[7:4]};
                state_d = T_CLO;
            end
            T_CLO: begin
                char_d = {framer_pkg::NIB_TAG, ck_q[3:0]};
                state_d = T_STOP;
            end
            T_STOP: begin
                char_d = framer_pkg::STOP_CHAR;
                state_d = T_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= T_IDLE;
        end else if (accept_start || advance) begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            char_q <= '0;
            valid_q <= 1'b0;
        end else if (advance) begin
            char_q <= char_d;
            valid_q <= 1'b1;
        end else if (line_tx_ready) begin
            valid_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lsh_q <= framer_pkg::LEN_RESET;
            cnt_q <= framer_pkg::LEN_RESET;
            idx_q <= '0;
        end else if (accept_start) begin
            lsh_q <= tx_len;
            cnt_q <= tx_len;
            idx_q <= '0;
        end else if (advance && state_q == T_LEN) begin
            lsh_q <= {lsh_q[11:0], 4'h0};
            idx_q <= idx_q + 2'h1;
        end else if (advance && state_q == T_DLO) begin
            cnt_q <= cnt_q - 16'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            byte_q <= '0;
            sum_q <= framer_pkg::SUM_RESET;
            ck_q <= framer_pkg::SUM_RESET;
        end else if (accept_start) begin
            sum_q <= framer_pkg::SUM_RESET;
        end else if (fifo_ready) begin
            byte_q <= fifo_data;
            sum_q <= 8'(sum_q + fifo_data);
        end else if (advance && state_q == T_CHI) begin
            ck_q <= ck_d;
        end
    end

    // busy covers the last character until the controller takes it
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= accept_start || (state_q != T_IDLE) || (valid_q && !line_tx_ready);
        end
    end

    assign line_tx_char = char_q;
    assign line_tx_valid = valid_q;
    assign tx_busy = busy_q;

    // count of characters sent in the current block, for the 2N+8 check
    logic [17:0] nchars_q;
    logic [15:0] blk_len_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            nchars_q <= '0;
            blk_len_q <= framer_pkg::LEN_RESET;
        end else if (accept_start) begin
            nchars_q <= '0;
            blk_len_q <= tx_len;
        end else if (advance) begin
            nchars_q <= nchars_q + 18'h1;
        end
    end

    tx_start_char_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == T_START && advance) |=> line_tx_char == framer_pkg::START_CHAR)
        else $error("block did not open with start character");
    tx_char_range_a: assert property (@(posedge clk) disable iff (rst)
        (advance && state_q inside {T_LEN, T_DHI, T_DLO, T_CHI, T_CLO})
        |=> line_tx_char >= 7'h40 && line_tx_char <= 7'h4f)
        else $error("encoded character outside 64..79");
    tx_len_order_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == T_LEN && advance) |=> line_tx_char[3:0] == $past(lsh_q[15:12]))
        else $error("length nibble out of order");
    tx_byte_lo_a: assert property (@(posedge clk) disable iff (rst)
        fifo_ready |=> (state_q == T_DLO) && line_tx_char[3:0] == $past(fifo_data[7:4]))
        else $error("high nibble not sent first");
    tx_cksum_zero_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == T_CLO && advance) |=> 8'(sum_q + ck_q) == 8'h00)
        else $error("checksum does not zero the sum");
    tx_stop_len_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == T_STOP && advance) |=> line_tx_char == framer_pkg::STOP_CHAR
        && nchars_q == 18'(2 * blk_len_q) + 18'd8)
        else $error("stop character or block length wrong");
    tx_len_load_a: assert property (@(posedge clk) disable iff (rst)
        accept_start |=> cnt_q == $past(tx_len) && state_q == T_START)
        else $error("length not latched from request");
    tx_hold_a: assert property (@(posedge clk) disable iff (rst)
        (line_tx_valid && !line_tx_ready) |=> line_tx_valid && $stable(line_tx_char))
        else $error("character dropped while stalled");

    // request handling and the place of every character in the block
    tx_refuse_a: assert property (@(posedge clk) disable iff (rst)
        (tx_start && state_q != T_IDLE) |=> $stable(blk_len_q))
        else $error("request taken while a block was in progress");
    tx_busy_a: assert property (@(posedge clk) disable iff (rst)
        accept_start |=> tx_busy)
        else $error("busy not raised for a taken request");
    tx_idle_busy_a: assert property (@(posedge clk) disable iff (rst)
        !tx_busy |-> state_q == T_IDLE)
        else $error("busy low while a block is in progress");
    tx_idle_hold_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == T_IDLE && !accept_start) |=> state_q == T_IDLE)
        else $error("block began without a request");
    tx_len_first_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == T_START && advance) |=> state_q == T_LEN && idx_q == 2'h0)
        else $error("length field did not follow the start character");
    tx_len_end_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == T_LEN && advance && last_len) |=> state_q != T_LEN)
        else $error("more than four length characters");
    tx_empty_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == T_LEN && advance && last_len && zero_len) |=> state_q == T_CHI)
        else $error("empty block did not go straight to the checksum");
    tx_wait_data_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == T_DHI && !fifo_valid) |=> state_q == T_DHI)
        else $error("data character sent without a payload byte");
    tx_fifo_pop_a: assert property (@(posedge clk) disable iff (rst)
        fifo_ready |-> state_q == T_DHI && fifo_valid && slot_free)
        else $error("payload byte taken outside a data slot");
    tx_data_lo_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == T_DLO && advance) |=> line_tx_char[3:0] == $past(byte_q[3:0]))
        else $error("low nibble not sent second");
    tx_ck_hi_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == T_CHI && advance) |=> line_tx_char[3:0] == ck_q[7:4])
        else $error("checksum high nibble wrong");
    tx_ck_lo_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == T_CLO && advance) |=> line_tx_char[3:0] == ck_q[3:0])
        else $error("checksum low nibble wrong");
    tx_stop_idle_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == T_STOP && advance) |=> state_q == T_IDLE && line_tx_valid)
        else $error("block did not end after the stop character");
    tx_char_step_a: assert property (@(posedge clk) disable iff (rst)
        advance |=> nchars_q == 18'($past(nchars_q) + 18'h1))
        else $error("character count skipped");

    // covers: a full block, an empty block and a stalled fill
    tx_block_cov: cover property (@(posedge clk) disable iff (rst)
        state_q == T_STOP && advance);
    tx_zero_cov: cover property (@(posedge clk) disable iff (rst)
        accept_start && tx_len == 16'h0000);
    tx_full_cov: cover property (@(posedge clk) disable iff (rst)
        tx_data_valid && !tx_data_ready);
endmodule // block_framer

// ### src/framer_pkg.sv
// shared constants for the block framer and deframer
package framer_pkg;
    localparam int CHAR_W = 7;
    localparam int BYTE_W = 8;
    localparam int LEN_W = 16;
    localparam int LEN_NIBBLES = 4;
    localparam int FIFO_DEPTH = 8;
    localparam logic [6:0] START_CHAR = 7'h23;
    localparam logic [6:0] STOP_CHAR = 7'h0d;
    localparam logic [2:0] NIB_TAG = 3'h4;
    localparam logic [7:0] OP_OPEN = 8'h01;
    localparam logic [7:0] OP_MAKE = 8'h02;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRITE = 8'h04;
    localparam logic [7:0] OP_CLOSE = 8'h05;
    localparam logic [7:0] OP_END = 8'h06;
    localparam logic [15:0] LEN_RESET = 16'h0000;
    localparam logic [7:0] SUM_RESET = 8'h00;
    localparam logic [1:0] LAST_NIBBLE = 2'h3;
endpackage

// ### src/byte_fifo.sv
// synchronous valid/ready fifo
`timescale 1ns/10ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] count_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    wire [AW:0] count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);

    // flags come from registered count only, so both ports are flop outputs
    assign in_ready = (count_q != FULL_COUNT);
    assign out_valid = (count_q != '0);
    assign out_data = mem_q[rd_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
            end
            count_q <= count_d;
        end
    end

    fifo_bound_a: assert property (@(posedge clk) disable iff (rst)
        count_q <= FULL_COUNT)
        else $error("fifo count above depth");
endmodule // byte_fifo

// ### src/block_deframer.sv
// receive side: line characters back to payload bytes
`timescale 1ns/10ps
module block_deframer (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // line characters from the serial controller
    input wire logic [6:0] line_rx_char,
    input wire logic line_rx_valid,
    // payload out
    output logic [7:0] rx_byte,
    output logic rx_byte_valid,
    output logic [15:0] rx_len,
    output logic [7:0] rx_opcode,
    output logic rx_done,
    output logic rx_error
);
    typedef enum logic [2:0] {R_HUNT, R_LEN, R_DHI, R_DLO, R_CHI, R_CLO, R_STOP} rx_state_e;

    rx_state_e state_q;
    logic [1:0] idx_q;
    logic [15:0] cnt_q;
    logic [3:0] hi_q;
    logic [7:0] sum_q;
    logic sum_ok_q;
    logic first_q;

    wire nib_ok = (line_rx_char[6:4] == framer_pkg::NIB_TAG);
    wire [3:0] nib = line_rx_char[3:0];
    wire [7:0] byte_in = {hi_q, nib};
    wire [7:0] sum_next = 8'(sum_q + byte_in);
    wire [15:0] len_next = {rx_len[11:0], nib};
    wire in_body = (state_q != R_HUNT) && (state_q != R_STOP);
    wire bad_char = line_rx_valid && in_body && !nib_ok;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= R_HUNT;
            idx_q <= '0;
            cnt_q <= framer_pkg::LEN_RESET;
            hi_q <= '0;
            sum_q <= framer_pkg::SUM_RESET;
            sum_ok_q <= 1'b0;
            first_q <= 1'b0;
            rx_byte <= '0;
            rx_byte_valid <= 1'b0;
            rx_len <= framer_pkg::LEN_RESET;
            rx_opcode <= '0;
            rx_done <= 1'b0;
            rx_error <= 1'b0;
        end else begin
            rx_byte_valid <= 1'b0;
            rx_done <= 1'b0;
            rx_error <= 1'b0;
            if (bad_char) begin
                // user must drop bytes already seen for this block
                state_q <= R_HUNT;
                rx_error <= 1'b1;
            end else if (line_rx_valid) begin
                unique case (state_q)
                    R_HUNT: if (line_rx_char == framer_pkg::START_CHAR) begin
                        state_q <= R_LEN;
                        idx_q <= '0;
                        sum_q <= framer_pkg::SUM_RESET;
                        first_q <= 1'b1;
                    end
                    R_LEN: begin
                        rx_len <= len_next;
                        idx_q <= idx_q + 2'h1;
                        if (idx_q == framer_pkg::LAST_NIBBLE) begin
                            cnt_q <= len_next;
                            state_q <= (len_next == '0) ? R_CHI : R_DHI;
                        end
                    end
                    R_DHI: begin
                        hi_q <= nib;
                        state_q <= R_DLO;
                    end
                    R_DLO: begin
                        rx_byte <= byte_in;
                        rx_byte_valid <= 1'b1;
                        sum_q <= sum_next;
                        cnt_q <= cnt_q - 16'h1;
                        first_q <= 1'b0;
                        if (first_q) begin
                            rx_opcode <= byte_in;
                        end
                        state_q <= (cnt_q == 16'h1) ? R_CHI : R_DHI;
                    end
                    R_CHI: begin
                        hi_q <= nib;
                        state_q <= R_CLO;
                    end
                    R_CLO: begin
                        sum_ok_q <= (sum_next == 8'h00);
                        state_q <= R_STOP;
                    end
                    R_STOP: begin
                        state_q <= R_HUNT;
                        if (line_rx_char == framer_pkg::STOP_CHAR && sum_ok_q) begin
                            rx_done <= 1'b1;
                        end else begin
                            rx_error <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    rx_range_err_a: assert property (@(posedge clk) disable iff (rst)
        bad_char |=> rx_error && state_q == R_HUNT)
        else $error("out of range character not flagged");
    rx_done_sum_a: assert property (@(posedge clk) disable iff (rst)
        rx_done |-> $past(sum_ok_q) && $past(line_rx_char) == framer_pkg::STOP_CHAR)
        else $error("block accepted without good checksum and stop");
    rx_no_both_a: assert property (@(posedge clk) disable iff (rst)
        !(rx_done && rx_error))
        else $error("block both accepted and rejected");
    rx_done_cov: cover property (@(posedge clk) disable iff (rst) rx_done);
    rx_error_cov: cover property (@(posedge clk) disable iff (rst) rx_error);
endmodule // block_deframer

// ### testbench/remote_end.sv
// far-side model: collects transmitted characters, sends received ones
`timescale 1ns/10ps
module remote_end (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // characters from the framer
    input wire logic [6:0] line_tx_char,
    input wire logic line_tx_valid,
    output logic line_tx_ready,
    // characters to the deframer
    output logic [6:0] line_rx_char,
    output logic line_rx_valid,
    // pace control
    input wire logic slow
);
    logic [6:0] got[$];
    logic [1:0] pace_q;

    initial begin
        line_tx_ready = 1'b0;
        line_rx_char = 7'h00;
        line_rx_valid = 1'b0;
        pace_q = 2'h0;
    end

    // a slow line takes one character in four
    always @(posedge clk) begin
        pace_q <= pace_q + 2'h1;
        line_tx_ready <= !rst && (!slow || pace_q == 2'h2);
        if (line_tx_valid === 1'b1 && line_tx_ready === 1'b1) begin
            got.push_back(line_tx_char);
        end
    end

    // idle line shows the inverse, never a stale copy of the last character
    task automatic send(input logic [6:0] c);
        @(posedge clk);
        line_rx_char <= c;
        line_rx_valid <= 1'b1;
        @(posedge clk);
        line_rx_valid <= 1'b0;
        line_rx_char <= ~c;
    endtask
endmodule // remote_end

// ### testbench/tb.sv
// self-checking bench for the block framer and deframer
`timescale 1ns/10ps
module tb;
    logic clk;
    logic rst;
    logic tx_start;
    logic [15:0] tx_len;
    logic tx_busy;
    logic tx_data_valid;
    logic tx_data_ready;
    logic [7:0] tx_data;
    logic [6:0] line_tx_char;
    logic line_tx_valid;
    logic line_tx_ready;
    logic [6:0] line_rx_char;
    logic line_rx_valid;
    logic [7:0] rx_byte;
    logic rx_byte_valid;
    logic [15:0] rx_len;
    logic [7:0] rx_opcode;
    logic rx_done;
    logic rx_error;
    logic slow;
    int n_fail;
    int checks;
    int cycles;
    int n_done;
    int n_err;
    logic [7:0] pay[$];
    logic [7:0] rxq[$];
    logic [6:0] blk[$];

    block_framer block_framer_inst (.clk(clk), .rst(rst), .tx_start(tx_start), .tx_len(tx_len),
        .tx_busy(tx_busy), .tx_data_valid(tx_data_valid), .tx_data_ready(tx_data_ready),
        .tx_data(tx_data), .line_tx_char(line_tx_char), .line_tx_valid(line_tx_valid),
        .line_tx_ready(line_tx_ready), .line_rx_char(line_rx_char),
        .line_rx_valid(line_rx_valid), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid),
        .rx_len(rx_len), .rx_opcode(rx_opcode), .rx_done(rx_done), .rx_error(rx_error));

    remote_end remote_end_inst (.clk(clk), .rst(rst), .line_tx_char(line_tx_char),
        .line_tx_valid(line_tx_valid), .line_tx_ready(line_tx_ready),
        .line_rx_char(line_rx_char), .line_rx_valid(line_rx_valid), .slow(slow));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // receive monitor and hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (rx_byte_valid === 1'b1) rxq.push_back(rx_byte);
        if (rx_done === 1'b1) n_done <= n_done + 1;
        if (rx_error === 1'b1) n_err <= n_err + 1;
        if (cycles == 40000) begin
            n_fail++;
            complete_run();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // expected line image of the payload queue
    task automatic encode(input logic [15:0] n);
        logic [7:0] sum;
        sum = 8'h00;
        blk.delete();
        blk.push_back(7'h23);
        for (int i = 3; i >= 0; i--) blk.push_back({3'h4, n[i*4 +: 4]});
        foreach (pay[i]) begin
            blk.push_back({3'h4, pay[i][7:4]});
            blk.push_back({3'h4, pay[i][3:0]});
            sum = sum + pay[i];
        end
        sum = 8'h00 - sum;
        blk.push_back({3'h4, sum[7:4]});
        blk.push_back({3'h4, sum[3:0]});
        blk.push_back(7'h0d);
    endtask

    task automatic push(input logic [7:0] b);
        @(posedge clk);
        tx_data <= b;
        tx_data_valid <= 1'b1;
        do @(negedge clk); while (tx_data_ready !== 1'b1);
        @(posedge clk);
        tx_data_valid <= 1'b0;
    endtask

    task automatic start(input logic [15:0] n);
        @(posedge clk);
        tx_start <= 1'b1;
        tx_len <= n;
        @(posedge clk);
        tx_start <= 1'b0;
    endtask

    task automatic finish_tx();
        int k;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while ((tx_busy !== 1'b0 || remote_end_inst.got.size() < blk.size()) && k < 2000);
        repeat (8) @(negedge clk);
        check(k < 2000, 1);
        check(remote_end_inst.got.size(), blk.size());
        foreach (blk[i]) check(remote_end_inst.got[i], blk[i]);
        remote_end_inst.got.delete();
    endtask

    task automatic rx_block();
        rxq.delete();
        foreach (blk[i]) remote_end_inst.send(blk[i]);
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    // full fifo, slow line, a second request while busy
    task automatic tx_fill_stall();
        pay = '{framer_pkg::OP_WRITE, 8'h00, 8'h00, 8'hff, 8'h80, 8'h7f, 8'h01, 8'hc3};
        @(posedge clk);
        slow <= 1'b1;
        foreach (pay[i]) push(pay[i]);
        @(negedge clk);
        check(tx_data_ready, 1'b0);
        encode(16'd8);
        start(16'd8);
        start(16'd3);
        finish_tx();
        @(posedge clk);
        slow <= 1'b0;
    endtask

    // short block then an empty one straight after
    task automatic tx_back_to_back();
        pay = '{framer_pkg::OP_CLOSE, 8'h00, 8'h00};
        foreach (pay[i]) push(pay[i]);
        encode(16'd3);
        start(16'd3);
        finish_tx();
        pay.delete();
        encode(16'd0);
        start(16'd0);
        finish_tx();
    endtask

    // bad sum, out-of-range characters, lost stop
    task automatic rx_faults();
        int d0;
        int e0;
        for (int k = 0; k < 4; k++) begin
            pay = '{framer_pkg::OP_READ, 8'h00, 8'h00};
            encode(16'd3);
            case (k)
                0: blk[12] = blk[12] ^ 7'h01;
                1: blk[6] = 7'h50;
                2: blk[13] = 7'h40;
                default: blk[3] = 7'h3f;
            endcase
            d0 = n_done;
            e0 = n_err;
            rx_block();
            check(n_err - e0, 1);
            check(n_done - d0, 0);
        end
    endtask

    // every opcode as an answer, open with a name, junk before the first
    task automatic rx_opcodes();
        logic [7:0] ops[6];
        int d0;
        int e0;
        ops = '{framer_pkg::OP_OPEN, framer_pkg::OP_MAKE, framer_pkg::OP_READ,
            framer_pkg::OP_WRITE, framer_pkg::OP_CLOSE, framer_pkg::OP_END};
        remote_end_inst.send(7'h41);
        foreach (ops[j]) begin
            pay = '{ops[j], 8'h00, 8'h90 + 8'(j)};
            if (j == 0) for (int i = 0; i < 16; i++) pay.push_back(8'h41 + 8'(i));
            encode(16'(pay.size()));
            d0 = n_done;
            e0 = n_err;
            rx_block();
            check(rxq.size(), pay.size());
            foreach (pay[i]) check(rxq[i], pay[i]);
            check(rx_opcode, ops[j]);
            check(rx_len, pay.size());
            check(n_done - d0, 1);
            check(n_err - e0, 0);
        end
    endtask

    initial begin
        rst = 1'b1;
        tx_start = 1'b0;
        tx_len = 16'h0000;
        tx_data_valid = 1'b0;
        tx_data = 8'h00;
        slow = 1'b0;
        n_fail = 0;
        checks = 0;
        cycles = 0;
        n_done = 0;
        n_err = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        tx_fill_stall();
        tx_back_to_back();
        rx_faults();
        rx_opcodes();
        complete_run();
    end
endmodule // tb
